// ===== rtl/tes_pkg.sv
// Package with offsets, field positions and reset values of the 16-bit timer
package tes_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] TES_OFF_MODE   = 8'h00; // timer_mode_ctrl
  localparam logic [7:0] TES_OFF_CCCTRL = 8'h04; // capture_compare_ctrl
  localparam logic [7:0] TES_OFF_OUTCTL = 8'h08; // output_ctrl_reg
  localparam logic [7:0] TES_OFF_PRESC  = 8'h0C; // prescale_mode_reg
  localparam logic [7:0] TES_OFF_CMPA   = 8'h10; // compare_a
  localparam logic [7:0] TES_OFF_CMPB   = 8'h14; // compare_b
  localparam logic [7:0] TES_OFF_COUNT  = 8'h18; // main_count, read only
  localparam logic [7:0] TES_OFF_STATUS = 8'h1C; // overflow flag and one-shot state

  // ----------------------------------------------------------------
  // Register indices returned by the address decoder
  // ----------------------------------------------------------------
  localparam logic [3:0] TES_IDX_MODE   = 4'h0;
  localparam logic [3:0] TES_IDX_CCCTRL = 4'h1;
  localparam logic [3:0] TES_IDX_OUTCTL = 4'h2;
  localparam logic [3:0] TES_IDX_PRESC  = 4'h3;
  localparam logic [3:0] TES_IDX_CMPA   = 4'h4;
  localparam logic [3:0] TES_IDX_CMPB   = 4'h5;
  localparam logic [3:0] TES_IDX_COUNT  = 4'h6;
  localparam logic [3:0] TES_IDX_STATUS = 4'h7;
  localparam logic [3:0] TES_IDX_NONE   = 4'hF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TES_RUN_LSB    = 2;  // run_mode_bit_low, run_mode_bit_high at 3
  localparam int TES_OE_BIT     = 0;  // output_enable_bit
  localparam int TES_TOGA_BIT   = 1;  // toggle_on_match_a_bit
  localparam int TES_TOGB_BIT   = 4;  // toggle on match B
  localparam int TES_OSEN_BIT   = 5;  // one-shot output enable
  localparam int TES_OSPT_BIT   = 6;  // oneshot_trigger_bit, write-only pulse
  localparam int TES_CSEL_LSB   = 0;  // count clock select, 2 bits
  localparam int TES_ES_LSB     = 4;  // edge_select_low, edge_select_high at 5
  localparam int TES_OVF_BIT    = 0;  // overflow_flag in status
  localparam int TES_OSACT_BIT  = 1;  // one-shot pulse in progress

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TES_RUN_STOP    = 2'b00; // operation stopped
  localparam logic [1:0] TES_RUN_EDGECLR = 2'b01; // clear and start on valid edge
  localparam logic [1:0] TES_RUN_FREE    = 2'b10; // free running
  localparam logic [1:0] TES_RUN_MATCHA  = 2'b11; // clear and start on match A
  localparam logic [1:0] TES_ES_FALL     = 2'b00;
  localparam logic [1:0] TES_ES_RISE     = 2'b01;
  localparam logic [1:0] TES_ES_BOTH     = 2'b11;
  localparam logic [1:0] TES_CSEL_DIV1   = 2'b00; // main_sys_clock
  localparam logic [1:0] TES_CSEL_DIV4   = 2'b01;
  localparam logic [1:0] TES_CSEL_DIV16  = 2'b10;
  localparam logic [1:0] TES_CSEL_EVENT  = 2'b11; // event input valid edges

  // ----------------------------------------------------------------
  // Prescaler terminal counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  TES_DIV4_LAST  = 4'h3;
  localparam logic [3:0]  TES_DIV16_LAST = 4'hF;
  localparam logic [15:0] TES_COUNT_MAX  = 16'hFFFF;
  localparam logic [15:0] TES_CMP_RST    = 16'h0000;
  localparam logic [15:0] TES_COUNT_RST  = 16'h0000;

endpackage

// ===== rtl/tes_edge_filter.sv
// Two-sample noise filter for the event input pin with edge pulses
`timescale 1ns/100ps
`default_nettype none

module tes_edge_filter
  import tes_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output logic      risePulse,
  output logic      fallPulse
);

  logic sampleReg;
  logic levelReg;
  logic newLevel;

  // ----------------------------------------------------------------
  // Accept a new level only after two equal consecutive samples
  // ----------------------------------------------------------------
  assign newLevel = (pinIn == sampleReg) && (sampleReg != levelReg); // R5

  // Sample history and filtered level
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sampleReg <= 1'b0;
      levelReg  <= 1'b0;
      risePulse <= 1'b0;
      fallPulse <= 1'b0;
    end else begin
      sampleReg <= pinIn;
      if (newLevel) begin
        levelReg <= sampleReg;
      end
      risePulse <= newLevel && sampleReg;
      fallPulse <= newLevel && !sampleReg;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/tes_timer16.sv
// 16-bit timer/event counter with square-wave and one-shot output, AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R1: Event mode: count one per valid filtered edge of the event input.
// R2: Match A in clear mode clears count to zero and pulses match A request.
// R3: Software keeps compare A nonzero in event-counter mode.
// R4: Prescale bits 5:4 pick falling, rising or both edges.
// R5: Edge acts only after new level seen on two consecutive clock samples.
// R6: Overflow flag sets only when count wraps from all ones.
// R7: Software reads the count register for the number of events.
// R8: Software programs everything else before writing run mode.
// R9: Software leaves compare A alone while square wave runs.
// R10: Output enable plus toggle-on-A inverts pin every compare A plus one ticks.
// R11: Writing one to trigger bit clears and restarts the counter.
// R12: One-shot with B below A: active at B, inactive at A.
// R13: B above A: active at A, inactive at B; never equal values.
// R14: Counter keeps running after one-shot; only run mode 00 stops it.
// R15: Software does not retrigger during an active pulse.
// R16: Valid edge also restarts counter in software one-shot mode.
// R17: Software loads both compare registers nonzero before one-shot.
// R18: One-shot starts from trigger bit or a valid event edge.
// R19: External edge clears and starts; output follows both compares.
// R20: Square-wave match A also clears count and pulses match A request.
module tes_timer16
  import tes_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        eventInputPin,
  output logic             timerOutputPin,
  output logic             matchAIrq,
  output logic             matchBIrq
);

  // ----------------------------------------------------------------
  // Address decoder shared by read and write paths
  // ----------------------------------------------------------------
  function automatic logic [3:0] decodeIdx(input logic [7:0] addr);
    logic [3:0] idx;
    idx = TES_IDX_NONE;
    if (addr == TES_OFF_MODE) begin
      idx = TES_IDX_MODE;
    end else if (addr == TES_OFF_CCCTRL) begin
      idx = TES_IDX_CCCTRL;
    end else if (addr == TES_OFF_OUTCTL) begin
      idx = TES_IDX_OUTCTL;
    end else if (addr == TES_OFF_PRESC) begin
      idx = TES_IDX_PRESC;
    end else if (addr == TES_OFF_CMPA) begin
      idx = TES_IDX_CMPA;
    end else if (addr == TES_OFF_CMPB) begin
      idx = TES_IDX_CMPB;
    end else if (addr == TES_OFF_COUNT) begin
      idx = TES_IDX_COUNT;
    end else if (addr == TES_OFF_STATUS) begin
      idx = TES_IDX_STATUS;
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [1:0]  runModeReg;
  logic [2:0]  ccCtrlReg;
  logic        outEnableReg;
  logic        toggleAReg;
  logic        toggleBReg;
  logic        oneShotEnReg;
  logic [1:0]  clockSelReg;
  logic [1:0]  edgeSelReg;
  logic [15:0] compareAReg;
  logic [15:0] compareBReg;
  logic [15:0] countReg;
  logic [15:0] countNext;
  logic [3:0]  divReg;
  logic        overflowReg;
  logic        oneShotActReg;
  logic        levelReg;
  logic        levelNext;
  logic        wrPendReg;
  logic [3:0]  wrIdxReg;

  // ----------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------
  logic        addrPhase;
  logic [3:0]  addrIdx;
  logic        rdTake;
  logic        wrTake;
  logic [31:0] rdData;

  assign addrPhase = hsel && htrans[1] && hready;
  assign addrIdx   = decodeIdx(haddr[7:0]);
  assign rdTake    = addrPhase && !hwrite;
  assign wrTake    = addrPhase && hwrite;

  // Write strobes for the data phase
  logic wrMode;
  logic wrCcCtrl;
  logic wrOutCtl;
  logic wrPresc;
  logic wrCmpA;
  logic wrCmpB;
  logic wrStatus;

  assign wrMode   = wrPendReg && (wrIdxReg == TES_IDX_MODE);
  assign wrCcCtrl = wrPendReg && (wrIdxReg == TES_IDX_CCCTRL);
  assign wrOutCtl = wrPendReg && (wrIdxReg == TES_IDX_OUTCTL);
  assign wrPresc  = wrPendReg && (wrIdxReg == TES_IDX_PRESC);
  assign wrCmpA   = wrPendReg && (wrIdxReg == TES_IDX_CMPA);
  assign wrCmpB   = wrPendReg && (wrIdxReg == TES_IDX_CMPB);
  assign wrStatus = wrPendReg && (wrIdxReg == TES_IDX_STATUS);

  // Read multiplexer; unmapped words read zero
  assign rdData =
    (addrIdx == TES_IDX_MODE)   ? {28'h0000000, runModeReg, 2'b00} :
    (addrIdx == TES_IDX_CCCTRL) ? {29'h00000000, ccCtrlReg} :
    (addrIdx == TES_IDX_OUTCTL) ? {26'h0000000, oneShotEnReg, toggleBReg, 2'b00,
                                   toggleAReg, outEnableReg} :
    (addrIdx == TES_IDX_PRESC)  ? {26'h0000000, edgeSelReg, 2'b00, clockSelReg} :
    (addrIdx == TES_IDX_CMPA)   ? {16'h0000, compareAReg} :
    (addrIdx == TES_IDX_CMPB)   ? {16'h0000, compareBReg} :
    (addrIdx == TES_IDX_COUNT)  ? {16'h0000, countReg} :             // R7
    (addrIdx == TES_IDX_STATUS) ? {30'h00000000, oneShotActReg, overflowReg} :
                                  32'h00000000;

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wrPendReg <= 1'b0;
      wrIdxReg  <= TES_IDX_NONE;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPendReg <= wrTake;
      wrIdxReg  <= addrIdx;
      if (rdTake) begin
        hrdata <= rdData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers written in the data phase
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      runModeReg   <= TES_RUN_STOP;
      ccCtrlReg    <= 3'h0;
      outEnableReg <= 1'b0;
      toggleAReg   <= 1'b0;
      toggleBReg   <= 1'b0;
      oneShotEnReg <= 1'b0;
      clockSelReg  <= TES_CSEL_DIV1;
      edgeSelReg   <= TES_ES_FALL;
      compareAReg  <= TES_CMP_RST;
      compareBReg  <= TES_CMP_RST;
    end else begin
      if (wrMode) begin
        runModeReg <= hwdata[TES_RUN_LSB +: 2];
      end
      if (wrCcCtrl) begin
        ccCtrlReg <= hwdata[2:0];
      end
      if (wrOutCtl) begin
        outEnableReg <= hwdata[TES_OE_BIT];
        toggleAReg   <= hwdata[TES_TOGA_BIT];
        toggleBReg   <= hwdata[TES_TOGB_BIT];
        oneShotEnReg <= hwdata[TES_OSEN_BIT];
      end
      if (wrPresc) begin
        clockSelReg <= hwdata[TES_CSEL_LSB +: 2];
        edgeSelReg  <= hwdata[TES_ES_LSB +: 2];
      end
      if (wrCmpA) begin
        compareAReg <= hwdata[15:0];
      end
      if (wrCmpB) begin
        compareBReg <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Event input filtering and edge selection
  // ----------------------------------------------------------------
  logic risePulse;
  logic fallPulse;
  logic validEdge;

  tes_edge_filter uEdgeFilter (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .pinIn     (eventInputPin),
    .risePulse (risePulse),
    .fallPulse (fallPulse)
  );

  // Edge select picks which filtered transitions count; 10 selects none
  assign validEdge =
    ((edgeSelReg == TES_ES_FALL) && fallPulse) ||                  // R4
    ((edgeSelReg == TES_ES_RISE) && risePulse) ||                  // R4
    ((edgeSelReg == TES_ES_BOTH) && (risePulse || fallPulse));     // R4

  // ----------------------------------------------------------------
  // Count clock, restart and match decode
  // ----------------------------------------------------------------
  logic running;
  logic eventClock;
  logic tick;
  logic swTrigger;
  logic edgeTrigger;
  logic restart;
  logic atCompareA;
  logic atCompareB;
  logic matchA;
  logic matchB;
  logic clearOnA;
  logic wrapAll;
  logic bFirst;

  assign running    = (runModeReg != TES_RUN_STOP);
  assign eventClock = (clockSelReg == TES_CSEL_EVENT);

  // Count clock: system clock, divided clock or event edges
  assign tick = running && (
    (clockSelReg == TES_CSEL_DIV1) ||
    ((clockSelReg == TES_CSEL_DIV4) && (divReg[1:0] == TES_DIV4_LAST[1:0])) ||
    ((clockSelReg == TES_CSEL_DIV16) && (divReg == TES_DIV16_LAST)) ||
    (eventClock && validEdge));                                    // R1

  // Trigger bit write, and a valid edge in edge-clear or one-shot mode without event clock, clear and start the counter
  assign swTrigger   = running && wrOutCtl && hwdata[TES_OSPT_BIT];  // R11
  assign edgeTrigger = running && !eventClock && validEdge &&
                       ((runModeReg == TES_RUN_EDGECLR) || oneShotEnReg); // R16 R19
  assign restart     = swTrigger || edgeTrigger;                     // R18

  assign atCompareA = (countReg == compareAReg);
  assign atCompareB = (countReg == compareBReg);
  assign matchA     = tick && !restart && atCompareA;
  assign matchB     = tick && !restart && atCompareB;
  assign clearOnA   = matchA && (runModeReg == TES_RUN_MATCHA);     // R2 R20
  assign wrapAll    = tick && !restart && (countReg == TES_COUNT_MAX); // R6
  assign bFirst     = (compareBReg < compareAReg);

  // Next count value
  assign countNext =
    !running ? TES_COUNT_RST :
    restart  ? TES_COUNT_RST :                                     // R11 R19
    clearOnA ? TES_COUNT_RST :                                     // R2 R20
    tick     ? countReg + 16'h0001 :                               // R1 R14
               countReg;

  // ----------------------------------------------------------------
  // Output level: one-shot sequencing or toggling on matches
  // ----------------------------------------------------------------
  logic osOn;
  logic osOff;

  assign osOn  = oneShotActReg && (bFirst ? matchB : matchA);       // R12 R13
  assign osOff = oneShotActReg && (bFirst ? matchA : matchB);       // R12 R13

  assign levelNext =
    !running     ? 1'b0 :
    oneShotEnReg ? (restart ? 1'b0 : osOn ? 1'b1 : osOff ? 1'b0 : levelReg) :
    ((toggleAReg && matchA) ^ (toggleBReg && matchB)) ? !levelReg : // R10
                   levelReg;

  // ----------------------------------------------------------------
  // Counter, prescaler and one-shot state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      countReg      <= TES_COUNT_RST;
      divReg        <= 4'h0;
      oneShotActReg <= 1'b0;
      levelReg      <= 1'b0;
    end else begin
      countReg <= countNext;
      divReg   <= (running && !restart) ? divReg + 4'h1 : 4'h0;
      levelReg <= levelNext;
      // Pulse in progress from trigger until its closing match
      if (!running || !oneShotEnReg) begin
        oneShotActReg <= 1'b0;                                     // R14
      end else if (restart) begin
        oneShotActReg <= 1'b1;                                     // R18
      end else if (osOff) begin
        oneShotActReg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag: set wins over a software clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      overflowReg <= 1'b0;
    end else if (wrapAll) begin
      overflowReg <= 1'b1;                                         // R6
    end else if (wrStatus && !hwdata[TES_OVF_BIT]) begin
      overflowReg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registered pin and match request outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timerOutputPin <= 1'b0;
      matchAIrq      <= 1'b0;
      matchBIrq      <= 1'b0;
    end else begin
      timerOutputPin <= outEnableReg && levelNext;                 // R10
      matchAIrq      <= matchA;                                    // R2 R20
      matchBIrq      <= matchB;
    end
  end

endmodule

`default_nettype wire

// ===== verif/tes_timer16_asserts.sv
// Checker on the bus, output pin and match request ports of the timer
`timescale 1ns/100ps
`default_nettype none

module tes_timer16_asserts
  import tes_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        timerOutputPin,
  input wire logic        matchAIrq,
  input wire logic        matchBIrq
);
  // ----------------------------------------------------------------
  // Shadow of mode and output control, loaded in the data phase
  // ----------------------------------------------------------------
  logic       wPend;
  logic [7:0] wAddr;
  logic [1:0] runSeen;
  logic [5:0] outSeen;
  wire        rdTake = hsel && htrans[1] && hready && !hwrite;

  // Tracks writes so mode-dependent checks know the setup
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wPend <= 1'h0;
      wAddr <= 8'h00;
      runSeen <= TES_RUN_STOP;
      outSeen <= 6'h00;
    end else begin
      wPend <= hsel && htrans[1] && hready && hwrite;
      wAddr <= haddr[7:0];
      if (wPend && wAddr == TES_OFF_MODE) runSeen <= hwdata[3:2];
      if (wPend && wAddr == TES_OFF_OUTCTL) outSeen <= hwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  hresp_okay_a: assert property (hresp == 1'h0)
    else $error("hresp not OKAY");
  ready_up_a: assert property (!$past(sys_rst) |-> hreadyout)
    else $error("hreadyout low after reset");
  rdata_hold_a: assert property (!$past(rdTake) |-> $stable(hrdata))
    else $error("hrdata moved without a read");
  unmapped_zero_a: assert property ($past(rdTake && haddr[7:0] >= 8'h20) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  oe_low_a: assert property ($past(!outSeen[TES_OE_BIT]) && !outSeen[TES_OE_BIT]
    |-> !timerOutputPin) else $error("output high while disabled");
  stop_low_a: assert property ($past(runSeen) == TES_RUN_STOP && runSeen == TES_RUN_STOP
    |-> !timerOutputPin) else $error("output high while stopped");
  sq_toggle_a: assert property (outSeen[1:0] == 2'h3 && !outSeen[TES_OSEN_BIT] &&
    runSeen == TES_RUN_MATCHA && matchAIrq |-> timerOutputPin != $past(timerOutputPin))
    else $error("no toggle on match A");
  irqa_pulse_a: assert property (matchAIrq |=> !matchAIrq)
    else $error("match A request too long");
  irqb_pulse_a: assert property (matchBIrq |=> !matchBIrq)
    else $error("match B request too long");

  cover property (matchAIrq);
  cover property ($fell(timerOutputPin));
  cover property (rdTake && haddr[7:0] >= 8'h20);
endmodule

`default_nettype wire

// ===== verif/tes_pin_model.sv
// Partner: pulse source on the event pin and a load that times the output
`timescale 1ns/100ps
`default_nettype none

module tes_pin_model (
  input  wire logic        mclk,
  input  wire logic        goPulse,
  input  wire logic [7:0]  pulseLen,
  input  wire logic        timerOutputPin,
  output var  logic        eventInputPin,
  output var  logic [15:0] lastSpan,
  output var  logic [15:0] hiSpan
);
  logic [7:0]  left;
  logic [15:0] cnt;
  logic        prevOut;

  // Known levels from time zero
  initial begin
    left = 8'h00;
    cnt = 16'h0;
    prevOut = 1'h0;
    eventInputPin = 1'h0;
    lastSpan = 16'h0;
    hiSpan = 16'h0;
  end

  // Push-pull source: pin high for pulseLen cycles, low otherwise
  always @(posedge mclk) begin
    if (goPulse) left <= pulseLen;
    else if (left != 8'h00) left <= left - 8'h01;
    eventInputPin <= goPulse || (left > 8'h01);
  end

  // Load: cycles between output changes and length of high phases
  always @(posedge mclk) begin
    prevOut <= timerOutputPin;
    if (timerOutputPin !== prevOut) begin
      lastSpan <= cnt;
      cnt <= 16'h0001;
    end else cnt <= cnt + 16'h0001;
    if (prevOut === 1'h1 && timerOutputPin === 1'h0) hiSpan <= cnt;
  end
endmodule

`default_nettype wire

// ===== verif/timer_event_square_oneshot_tb.sv
// Testbench: registers, event counting, square wave, one-shot, overflow
`timescale 1ns/100ps
`default_nettype none

module timer_event_square_oneshot_tb
  import tes_pkg::*;
();
  logic        mclk, sys_rst, hsel, hwrite, goPulse;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, eventInputPin, timerOutputPin, matchAIrq, matchBIrq;
  logic [7:0]  pulseLen;
  logic [15:0] lastSpan, hiSpan;
  int          errors, n_tests, nIrqA;

  tes_timer16 dut (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .eventInputPin,
    .timerOutputPin, .matchAIrq, .matchBIrq);
  tes_pin_model pm (.mclk, .goPulse, .pulseLen, .timerOutputPin, .eventInputPin,
    .lastSpan, .hiSpan);

  // Clock and match A request counter
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (matchAIrq === 1'h1) nIrqA <= nIrqA + 1;

  // ----------------------------------------------------------------
  // Bus, pin and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'h1) @(posedge mclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'h1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] junk;
    xfer(1'h1, a, d, junk);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] v);
    xfer(1'h0, a, 32'h0, v);
  endtask

  task automatic pulse(input logic [7:0] len);
    @(posedge mclk);
    goPulse <= 1'h1;
    pulseLen <= len;
    @(posedge mclk);
    goPulse <= 1'h0;
    repeat (len + 8) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] v;
    for (int i = 0; i <= 8; i++) begin
      rdr(8'(i * 4), v);
      chk("reset_word", 32'h0, v);
    end
    wr(TES_OFF_CMPB, 32'hFFFF1234);
    rdr(TES_OFF_CMPB, v);
    chk("cmpb_word", 32'h00001234, v);
    wr(TES_OFF_COUNT, 32'h55);
    rdr(TES_OFF_COUNT, v);
    chk("count_ro", 32'h0, v);
    wr(8'h24, 32'hAA);
    rdr(8'h24, v);
    chk("unmapped", 32'h0, v);
    $display("test regs done");
  endtask

  task automatic t_event();
    logic [31:0] v;
    logic [1:0]  esTab [3] = '{TES_ES_FALL, TES_ES_RISE, TES_ES_BOTH};
    logic [31:0] expTab [3] = '{32'h1, 32'h1, 32'h2};
    for (int i = 0; i < 3; i++) begin
      wr(TES_OFF_MODE, 32'h0);
      wr(TES_OFF_PRESC, {26'h0, esTab[i], 2'h0, TES_CSEL_EVENT});
      wr(TES_OFF_CMPA, 32'h5);
      wr(TES_OFF_MODE, 32'hC);
      pulse(8'h01);
      pulse(8'h06);
      rdr(TES_OFF_COUNT, v);
      chk("event_count", expTab[i], v);
    end
    wr(TES_OFF_MODE, 32'h0);
    wr(TES_OFF_CMPA, 32'h3);
    nIrqA = 0;
    wr(TES_OFF_MODE, 32'hC);
    pulse(8'h06);
    pulse(8'h06);
    rdr(TES_OFF_COUNT, v);
    chk("event_wrap", 32'h0, v);
    chk("event_irq", 32'h1, 32'(nIrqA));
    $display("test event done");
  endtask

  task automatic t_square(input logic [1:0] cs, input int span);
    logic [31:0] v;
    wr(TES_OFF_MODE, 32'h0);
    wr(TES_OFF_PRESC, {30'h0, cs});
    wr(TES_OFF_CMPA, 32'h4);
    wr(TES_OFF_OUTCTL, 32'h3);
    nIrqA = 0;
    wr(TES_OFF_MODE, 32'hC);
    repeat (8 * span) @(posedge mclk);
    chk("half_wave", span, {16'h0, lastSpan});
    rdr(TES_OFF_COUNT, v);
    chk("sq_count", 32'h1, {31'h0, v < 32'h5});
    chk("sq_irqs", 32'h1, {31'h0, nIrqA >= 6});
    wr(TES_OFF_MODE, 32'h0);
    $display("test square done");
  endtask

  task automatic t_oneshot(input logic [15:0] a, input logic [15:0] b, input logic ext,
                           input logic [1:0] runCode);
    logic [31:0] v;
    logic [15:0] w;
    w = (a > b) ? a - b : b - a;
    wr(TES_OFF_MODE, 32'h0);
    wr(TES_OFF_PRESC, ext ? 32'h10 : 32'h0);
    wr(TES_OFF_CMPA, {16'h0, a});
    wr(TES_OFF_CMPB, {16'h0, b});
    wr(TES_OFF_OUTCTL, 32'h21);
    wr(TES_OFF_MODE, {28'h0, runCode, 2'h0});
    if (ext) pulse(8'h06);
    else wr(TES_OFF_OUTCTL, 32'h61);
    repeat (60) @(posedge mclk);
    chk("pulse_width", {16'h0, w}, {16'h0, hiSpan});
    rdr(TES_OFF_COUNT, v);
    chk("count_runs", 32'h1, {31'h0, v != 32'h0});
    wr(TES_OFF_MODE, 32'h0);
    rdr(TES_OFF_COUNT, v);
    chk("count_stop", 32'h0, v);
    $display("test oneshot done");
  endtask

  task automatic t_overflow();
    logic [31:0] v;
    wr(TES_OFF_CMPA, 32'hFFFF);
    wr(TES_OFF_STATUS, 32'h0);
    wr(TES_OFF_MODE, 32'hC);
    rdr(TES_OFF_STATUS, v);
    chk("ovf_early", 32'h0, {31'h0, v[TES_OVF_BIT]});
    repeat (65540) @(posedge mclk);
    rdr(TES_OFF_STATUS, v);
    chk("ovf_set", 32'h1, {31'h0, v[TES_OVF_BIT]});
    wr(TES_OFF_MODE, 32'h0);
    wr(TES_OFF_STATUS, 32'h0);
    rdr(TES_OFF_STATUS, v);
    chk("ovf_clear", 32'h0, {31'h0, v[TES_OVF_BIT]});
    $display("test overflow done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence after reset
  initial begin
    mclk = 1'h0;
    sys_rst = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    goPulse = 1'h0;
    errors = 0;
    n_tests = 0;
    nIrqA = 0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge mclk);
    t_regs();
    t_event();
    t_square(TES_CSEL_DIV1, 5);
    t_square(TES_CSEL_DIV4, 20);
    t_square(TES_CSEL_DIV16, 80);
    t_oneshot(16'h0014, 16'h0008, 1'h0, TES_RUN_FREE);
    t_oneshot(16'h0006, 16'h0010, 1'h0, TES_RUN_FREE);
    t_oneshot(16'h0019, 16'h0008, 1'h1, TES_RUN_FREE);
    t_oneshot(16'h0009, 16'h001E, 1'h1, TES_RUN_EDGECLR);
    t_overflow();
    print_verdict();
  end

  // Watchdog past the run length
  initial begin
    repeat (80000) @(posedge mclk);
    errors++;
    $display("BAD watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule

bind tes_timer16 tes_timer16_asserts chkU (.mclk, .sys_rst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timerOutputPin, .matchAIrq,
  .matchBIrq);

`default_nettype wire
